// ==== common/phyevt_pkg.sv ====
//------------------------------------------------------------------------------
// shared constants for the event status collector
//------------------------------------------------------------------------------
package phyevt_pkg;

   //---------------------------------------------------------------------------
   // clock and timing
   //---------------------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 20_000_000;  // core clock rate
   localparam int unsigned JABBER_LIMIT_MS = 105;        // longest 10 Mb/s transmission
   // longest time, so round down; exact at 20 MHz
   localparam int unsigned JABBER_CYCLES  = JABBER_LIMIT_MS * (CLK_HZ / 1000);
   localparam int unsigned JAB_CNT_W      = 22;          // holds JABBER_CYCLES

   //---------------------------------------------------------------------------
   // register bus
   //---------------------------------------------------------------------------
   localparam int unsigned ADDR_W = 5;                   // register index width
   localparam int unsigned DATA_W = 16;                  // register width

   localparam logic [4:0] BASIC_STATUS_ADDR = 5'h01;     // basic status view
   localparam logic [4:0] EVENT_STATUS_ADDR = 5'h11;     // phy_event_status
   localparam logic [4:0] SELF_STATUS_ADDR  = 5'h19;     // live link state
   localparam logic [4:0] CONFIG_ADDR       = 5'h1C;     // compatibility bit
   localparam logic [4:0] EVENT_MASK_ADDR   = 5'h1E;     // per-event enables

   //---------------------------------------------------------------------------
   // phy_event_status field positions
   //---------------------------------------------------------------------------
   localparam int unsigned CIM_UNSTABLE_BIT  = 15;
   localparam int unsigned LINK_CHANGE_BIT   = 14;
   localparam int unsigned LOCK_CHANGE_BIT   = 13;
   localparam int unsigned PREMATURE_END_BIT = 12;
   localparam int unsigned DISC_MSB_BIT      = 11;
   localparam int unsigned FALSE_MSB_BIT     = 10;
   localparam int unsigned RXERR_MSB_BIT     = 9;
   localparam int unsigned ELASTIC_FAULT_BIT = 8;
   localparam int unsigned RESET_DONE_BIT    = 7;
   localparam int unsigned JABBER_BIT        = 6;
   localparam int unsigned AN_COMPLETE_BIT   = 5;
   localparam int unsigned PD_FAULT_BIT      = 4;
   localparam int unsigned PD_FAIL_BIT       = 3;
   localparam int unsigned REMOTE_FAULT_BIT  = 2;
   localparam int unsigned PAGE_RX_BIT       = 1;
   localparam logic [15:0] STATUS_RESET      = 16'h0000;
   localparam logic [15:0] STATUS_USED       = 16'hFFFE;  // bit 0 reads zero

   //---------------------------------------------------------------------------
   // other register fields
   //---------------------------------------------------------------------------
   localparam logic [15:0] MASK_RESET       = 16'h4080;   // link change, reset done
   localparam int unsigned COMPAT_BIT       = 0;          // in CONFIG_ADDR
   localparam int unsigned BASIC_AN_BIT     = 5;          // in BASIC_STATUS_ADDR
   localparam int unsigned BASIC_JABBER_BIT = 1;          // in BASIC_STATUS_ADDR
   localparam int unsigned SELF_LINK_BIT    = 0;          // in SELF_STATUS_ADDR
   localparam int unsigned SELF_LOCK_BIT    = 1;          // in SELF_STATUS_ADDR

   //---------------------------------------------------------------------------
   // elastic buffer and frame checks
   //---------------------------------------------------------------------------
   localparam int unsigned EB_DEPTH   = 10;               // bits of slip storage
   localparam int unsigned EB_LVL_W   = 4;
   localparam int unsigned IDLE_LIMIT = 2;                // consecutive idle codes

   typedef enum logic [1:0] {
      PHYEVT_JAB_IDLE   = 2'b00,
      PHYEVT_JAB_TIMING = 2'b01,
      PHYEVT_JAB_CUTOFF = 2'b10
   } phyevt_jab_state_t;

endpackage : phyevt_pkg

// ==== logic/phyevt_jabber_timer.sv ====
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// jabber watchdog for 10 Mb/s transmissions
//------------------------------------------------------------------------------
module phyevt_jabber_timer
   import phyevt_pkg::*;
#(
   parameter int unsigned LIMIT = JABBER_CYCLES           // cycles before cutoff
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic txActive,                            // transmit in progress
   input  wire logic tenMode,                             // 10BASE-T selected
   output logic      cutoff,                              // transmit held off
   output logic      jabEvent                             // one-cycle detection
);

   typedef struct packed {
      phyevt_jab_state_t      state;                      // watchdog phase
      logic [JAB_CNT_W-1:0]   count;                      // cycles of this frame
      logic                   cutoff;                     // registered cutoff
      logic                   jabEvent;                   // registered pulse
   } phyevt_jab_regs_t;

   phyevt_jab_regs_t r_q;                                 // current state
   phyevt_jab_regs_t r_d;                                 // next state

   localparam logic [JAB_CNT_W-1:0] LAST = JAB_CNT_W'(LIMIT - 1);

   //---------------------------------------------------------------------------
   // next state
   //---------------------------------------------------------------------------
   // fast ethernet has no jabber rule, so the timer only runs in ten mode
   always_comb begin
      r_d          = r_q;
      r_d.jabEvent = 1'b0;
      unique case (r_q.state)
         PHYEVT_JAB_IDLE: begin
            r_d.count = '0;
            if (txActive && tenMode) begin
               r_d.state = PHYEVT_JAB_TIMING;
            end
         end
         PHYEVT_JAB_TIMING: begin
            if (!txActive || !tenMode) begin
               r_d.state = PHYEVT_JAB_IDLE;
            end else if (r_q.count == LAST) begin
               r_d.state    = PHYEVT_JAB_CUTOFF;
               r_d.cutoff   = 1'b1;
               r_d.jabEvent = 1'b1;
            end else begin
               r_d.count = r_q.count + JAB_CNT_W'(1);
            end
         end
         PHYEVT_JAB_CUTOFF: begin
            // hold off until the mac gives up the frame
            if (!txActive) begin
               r_d.state  = PHYEVT_JAB_IDLE;
               r_d.cutoff = 1'b0;
            end
         end
         default: begin
            r_d.state  = PHYEVT_JAB_IDLE;
            r_d.cutoff = 1'b0;
         end
      endcase
   end

   //---------------------------------------------------------------------------
   // state register
   //---------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_q <= '{state: PHYEVT_JAB_IDLE, count: '0, cutoff: 1'b0, jabEvent: 1'b0};
      end else begin
         r_q <= r_d;
      end
   end

   assign cutoff   = r_q.cutoff;
   assign jabEvent = r_q.jabEvent;

endmodule : phyevt_jabber_timer

// ==== logic/phy_event_interrupt_status.sv ====
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// Functional notes
// - status register records interrupt causes
// - reading status clears every bit
// - bit 15 on carrier integrity instability
// - bit 14 on any link change
// - bit 13 on descrambler lock change
// - bit 12 on two idles before delimiter, at 100 Mb/s only
// - bit 11 when disconnect count msb sets
// - bit 10 when false carrier msb sets
// - bit 9 when receive error msb sets
// - bit 8 on elastic fault, abort frame
// - elastic buffer ten bits deep
// - bit 7 when calibration completes
// - ten mode jabber cutoff after 105 ms
// - jabber latched until either read or reset
// - no jabber in 100 Mb/s mode
// - bit 5 on auto-negotiation complete
// - bit 4 on parallel detection fault
// - bit 3 on unadvertised parallel detect
// - bit 2 on partner remote fault
// - bit 2 on far-end fault without negotiation, at 100 Mb/s only
// - bit 1 on each verified page
// - mask enables gate events onto interrupt
// - compatibility mode disables and locks mask
//------------------------------------------------------------------------------
module phy_event_interrupt_status
   import phyevt_pkg::*;
#(
   parameter int unsigned JAB_LIMIT = JABBER_CYCLES,      // shorten in simulation
   parameter int unsigned EBUF_DEPTH = EB_DEPTH           // elastic slip storage
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   // register port
   input  wire logic [ADDR_W-1:0] regAddr,                // register index
   input  wire logic [DATA_W-1:0] regWdata,               // write data
   input  wire logic              regWr,                  // write strobe
   input  wire logic              regRd,                  // read strobe
   output logic      [DATA_W-1:0] regRdata,               // data one cycle on
   // mode inputs
   input  wire logic              speed100,               // 100 Mb/s selected
   input  wire logic              anEnable,               // negotiation enabled
   // event sources
   input  wire logic              cimUnstable,            // integrity monitor pulse
   input  wire logic              linkUp,                 // link state level
   input  wire logic              descramLocked,          // lock state level
   input  wire logic              rxInFrame,              // inside a received frame
   input  wire logic              rxCodeStb,              // one code group seen
   input  wire logic              rxCodeIdle,             // that group was idle
   input  wire logic              rxEsdSeen,              // end_of_stream_delimiter
   input  wire logic              disconnectCountMsb,     // disconnect_count msb
   input  wire logic              falseCarrierCountMsb,   // false_carrier_count msb
   input  wire logic              receiveErrorCountMsb,   // receive_error_count msb
   input  wire logic              ebPush,                 // bit into elastic buffer
   input  wire logic              ebPop,                  // bit out of elastic buffer
   input  wire logic              calDone,                // calibration finished level
   input  wire logic              txActive,               // transmit in progress
   input  wire logic              anComplete,             // negotiation done pulse
   input  wire logic              pdFault,                // parallel detect fault pulse
   input  wire logic              pdFail,                 // unadvertised detect pulse
   input  wire logic              lpRemoteFault,          // partner fault flag level
   input  wire logic              farEndFault,            // far-end fault level
   input  wire logic              pageReceived,           // verified page pulse
   // outputs
   output logic                   irqN,                   // interrupt, active low
   output logic                   txJabberCutoff,         // transmit held off
   output logic                   frameAbort              // elastic fault abort
);

   //---------------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0]   status;                        // sticky event bits
      logic [DATA_W-1:0]   mask;                          // per-event enables
      logic                compat;                        // compatibility mode
      logic                prevLink;                      // for change detect
      logic                prevLock;                      // for change detect
      logic                prevDisc;                      // msb history
      logic                prevFalse;                     // msb history
      logic                prevRxErr;                     // msb history
      logic                prevCal;                       // calibration history
      logic                prevLpRf;                      // partner fault history
      logic                prevFef;                       // far-end fault history
      logic                histValid;                     // history loaded
      logic [1:0]          idleRun;                       // consecutive idles
      logic [EB_LVL_W-1:0] ebLevel;                       // elastic fill level
      logic [DATA_W-1:0]   rdata;                         // read data register
      logic                irqN;                          // registered pin
      logic                cutoff;                        // registered cutoff
      logic                frameAbort;                    // registered abort
   } phyevt_regs_t;

   phyevt_regs_t r_q;                                     // current state
   phyevt_regs_t r_d;                                     // next state

   logic jabCutoff;                                       // from watchdog
   logic jabEvent;                                        // watchdog detection

   localparam logic [EB_LVL_W-1:0] EB_FULL = EB_LVL_W'(EBUF_DEPTH);
   localparam logic [EB_LVL_W-1:0] EB_HALF = EB_LVL_W'(EBUF_DEPTH / 2);

   //---------------------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------------------
   // rising edge of a level, gated until history is valid after reset
   function automatic logic rose(input logic now, input logic prev, input logic ok);
      rose = ok && now && !prev;
   endfunction : rose

   // read strobe aimed at one register
   function automatic logic readOf(input logic [ADDR_W-1:0] a);
      readOf = regRd && (regAddr == a);
   endfunction : readOf

   //---------------------------------------------------------------------------
   // jabber watchdog
   //---------------------------------------------------------------------------
   phyevt_jabber_timer #(
      .LIMIT    (JAB_LIMIT)
   ) u_jabber (
      .clk      (clk),
      .resetn   (resetn),
      .txActive (txActive),
      .tenMode  (!speed100),
      .cutoff   (jabCutoff),
      .jabEvent (jabEvent)
   );

   //---------------------------------------------------------------------------
   // next state
   //---------------------------------------------------------------------------
   always_comb begin
      logic [DATA_W-1:0] events;                          // this cycle's causes
      logic [DATA_W-1:0] kept;                            // status after clears
      logic [DATA_W-1:0] effMask;                         // enables in force
      logic              ebOver;                          // push into full buffer
      logic              ebUnder;                         // pop from empty buffer
      logic              prematureEnd;                    // idle run completed
      events       = '0;
      kept         = '0;
      effMask      = '0;
      ebOver       = 1'b0;
      ebUnder      = 1'b0;
      prematureEnd = 1'b0;
      r_d          = r_q;

      // history is loaded one cycle after reset so levels already high at
      // release are not mistaken for fresh edges
      r_d.histValid = 1'b1;
      r_d.prevLink  = linkUp;
      r_d.prevLock  = descramLocked;
      r_d.prevDisc  = disconnectCountMsb;
      r_d.prevFalse = falseCarrierCountMsb;
      r_d.prevRxErr = receiveErrorCountMsb;
      r_d.prevCal   = calDone;
      r_d.prevLpRf  = lpRemoteFault;
      r_d.prevFef   = farEndFault;

      // premature end: idle groups counted only inside a 100 Mb/s frame
      if (!rxInFrame || rxEsdSeen || !speed100) begin
         r_d.idleRun = '0;
      end else if (rxCodeStb) begin
         if (!rxCodeIdle) begin
            r_d.idleRun = '0;
         end else if (r_q.idleRun == 2'(IDLE_LIMIT - 1)) begin
            prematureEnd = 1'b1;
            r_d.idleRun  = '0;
         end else begin
            r_d.idleRun = r_q.idleRun + 2'(1);
         end
      end

      // elastic buffer fill; simultaneous push and pop keeps the level
      ebOver  = ebPush && !ebPop && (r_q.ebLevel == EB_FULL);
      ebUnder = ebPop && !ebPush && (r_q.ebLevel == '0);
      if (ebOver || ebUnder) begin
         r_d.ebLevel = EB_HALF;                           // recentre for next frame
      end else if (ebPush && !ebPop) begin
         r_d.ebLevel = r_q.ebLevel + EB_LVL_W'(1);
      end else if (ebPop && !ebPush) begin
         r_d.ebLevel = r_q.ebLevel - EB_LVL_W'(1);
      end
      r_d.frameAbort = ebOver || ebUnder;

      // event collection
      events[CIM_UNSTABLE_BIT]  = cimUnstable;
      events[LINK_CHANGE_BIT]   = r_q.histValid && (linkUp != r_q.prevLink);
      events[LOCK_CHANGE_BIT]   = r_q.histValid && (descramLocked != r_q.prevLock);
      events[PREMATURE_END_BIT] = prematureEnd;
      events[DISC_MSB_BIT]  = rose(disconnectCountMsb, r_q.prevDisc, r_q.histValid);
      events[FALSE_MSB_BIT] = rose(falseCarrierCountMsb, r_q.prevFalse, r_q.histValid);
      events[RXERR_MSB_BIT] = rose(receiveErrorCountMsb, r_q.prevRxErr, r_q.histValid);
      events[ELASTIC_FAULT_BIT] = ebOver || ebUnder;
      events[RESET_DONE_BIT]    = rose(calDone, r_q.prevCal, r_q.histValid);
      events[JABBER_BIT]        = jabEvent;
      events[AN_COMPLETE_BIT]   = anComplete;
      events[PD_FAULT_BIT]      = pdFault;
      events[PD_FAIL_BIT]       = pdFail;
      // remote fault source depends on whether negotiation is running
      if (anEnable) begin
         events[REMOTE_FAULT_BIT] = rose(lpRemoteFault, r_q.prevLpRf, r_q.histValid);
      end else begin
         events[REMOTE_FAULT_BIT] = speed100 &&
                                    rose(farEndFault, r_q.prevFef, r_q.histValid);
      end
      events[PAGE_RX_BIT]       = pageReceived;

      // clearing reads; jabber also clears on a basic status read
      kept = r_q.status;
      if (readOf(EVENT_STATUS_ADDR)) begin
         kept = '0;
      end else if (readOf(BASIC_STATUS_ADDR)) begin
         kept[JABBER_BIT] = 1'b0;
      end
      // a new event in the clearing cycle survives the clear
      r_d.status = (kept | events) & STATUS_USED;

      // configuration writes
      if (regWr && (regAddr == CONFIG_ADDR)) begin
         r_d.compat = regWdata[COMPAT_BIT];
      end
      // mask is frozen while compatibility mode holds
      if (regWr && (regAddr == EVENT_MASK_ADDR) && !r_q.compat) begin
         r_d.mask = regWdata & STATUS_USED;
      end

      // read data, registered; unmapped indices answer zero
      r_d.rdata = '0;
      if (regRd) begin
         unique case (regAddr)
            EVENT_STATUS_ADDR: r_d.rdata = r_q.status;
            EVENT_MASK_ADDR:   r_d.rdata = r_q.mask;
            CONFIG_ADDR:       r_d.rdata[COMPAT_BIT] = r_q.compat;
            BASIC_STATUS_ADDR: begin
               r_d.rdata[BASIC_JABBER_BIT] = r_q.status[JABBER_BIT];
               r_d.rdata[BASIC_AN_BIT]     = r_q.status[AN_COMPLETE_BIT];
            end
            SELF_STATUS_ADDR: begin
               r_d.rdata[SELF_LINK_BIT] = linkUp;
               r_d.rdata[SELF_LOCK_BIT] = descramLocked;
            end
            default: r_d.rdata = '0;
         endcase
      end

      // interrupt pin follows the next status so it drops with the read
      effMask  = r_q.compat ? '0 : r_q.mask;
      r_d.irqN = ~|(r_d.status & effMask);

      r_d.cutoff = jabCutoff;
   end

   //---------------------------------------------------------------------------
   // state register
   //---------------------------------------------------------------------------
   // reset also clears the latched jabber bit with the rest of status
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_q            <= '0;
         r_q.status     <= STATUS_RESET;
         r_q.mask       <= MASK_RESET;
         r_q.ebLevel    <= EB_HALF;
         r_q.irqN       <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   //---------------------------------------------------------------------------
   // outputs, all straight from flops
   //---------------------------------------------------------------------------
   assign regRdata       = r_q.rdata;
   assign irqN           = r_q.irqN;
   assign txJabberCutoff = r_q.cutoff;
   assign frameAbort     = r_q.frameAbort;

endmodule : phy_event_interrupt_status

// ==== sim/phyevt_checker.sv ====
`timescale 1ns/1ps
//----------------------------
// port checks, status collector
//----------------------------
module phyevt_checker
   import phyevt_pkg::*;
(
   input wire logic              clk, resetn, regRd, irqN, frameAbort, txActive,
   input wire logic              txJabberCutoff, pdFail, cimUnstable, pageReceived,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regRdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // event, three idle cycles, then the first status read
   sequence rd_sts_s; regRd && regAddr == 5'h11; endsequence
   property evt_p(e, int b);
      e ##1 (!(regRd && regAddr == EVENT_STATUS_ADDR))[*3] ##1 rd_sts_s |=> regRdata[b];
   endproperty
   rdata_idle_a: assert property (!regRd |=> regRdata == 16'h0000)
      else $error("read data outside a read");
   bit0_zero_a: assert property (regRd |=> !regRdata[0])
      else $error("reserved bit set");
   cim_bit_a: assert property (evt_p(cimUnstable, 15))
      else $error("integrity event lost");
   pd_fail_a: assert property (evt_p(pdFail, 3))
      else $error("parallel fail lost");
   page_rx_a: assert property (evt_p(pageReceived, 1))
      else $error("page event lost");
   abort_pulse_a: assert property (frameAbort |=> !frameAbort)
      else $error("abort longer than a cycle");
   cutoff_drop_a: assert property ((!txActive)[*4] |-> !txJabberCutoff)
      else $error("cutoff without transmit");
   reset_idle_a: assert property (disable iff (1'b0)
      !resetn |=> irqN && !frameAbort && regRdata == 16'h0000) else $error("busy in reset");
endmodule : phyevt_checker
bind phy_event_interrupt_status phyevt_checker u_phyevt_checker (.*);

// ==== sim/phyevt_host_model.sv ====
`timescale 1ns/1ps
//----------------------------
// host side: counts interrupt requests
//----------------------------
module phyevt_host_model (
   input  wire logic clk,
   input  wire logic irqN,           // interrupt, active low
   output int        irqCount = 0    // falling edges seen
);
   logic irqN_q = 1'b1;              // last sampled level
   // a host reacts to the pin going low, so a held level counts once
   always @(posedge clk) begin
      if (irqN_q && !irqN) irqCount <= irqCount + 1;
      irqN_q <= irqN;
   end
endmodule : phyevt_host_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
//----------------------------
// bench for the status collector
//----------------------------
module tb;
   import phyevt_pkg::*;
   localparam int unsigned JL = 50;  // short jabber limit, keeps the run brief
   logic clk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0, speed100 = 1'b1;
   logic anEnable = 1'b1, txActive = 1'b0, rxInFrame = 1'b0, rxCodeStb = 1'b0;
   logic rxCodeIdle = 1'b0, rxEsdSeen = 1'b0, ebPush = 1'b0, ebPop = 1'b0;
   logic irqN, txJabberCutoff, frameAbort;
   logic [4:0] regAddr = 5'h00;
   logic [15:0] regWdata = 16'h0000, regRdata, v;
   logic [12:0] ev = 13'h0000;       // event lines, in table order
   int err_total = 0, compares = 0, cyc = 0, irqCount, n;
   int bitOf [13] = '{15, 14, 13, 11, 10, 9, 7, 5, 4, 3, 2, 1, 2};
   phy_event_interrupt_status #(.JAB_LIMIT(JL)) u_phy_event_interrupt_status (.*,
      .cimUnstable(ev[0]), .linkUp(ev[1]), .descramLocked(ev[2]), .disconnectCountMsb(ev[3]),
      .falseCarrierCountMsb(ev[4]), .receiveErrorCountMsb(ev[5]), .calDone(ev[6]),
      .anComplete(ev[7]), .pdFault(ev[8]), .pdFail(ev[9]), .lpRemoteFault(ev[10]),
      .pageReceived(ev[11]), .farEndFault(ev[12]));
   phyevt_host_model u_phyevt_host_model (.*);
   initial forever #25 clk = ~clk;
   // cut a hang short
   always @(posedge clk) if (++cyc == 6000) begin err_total++; finish_test(); end
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end
   endtask : chk
   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(posedge clk) begin regWr <= 1'b1; regAddr <= a; regWdata <= d; end
      @(posedge clk) regWr <= 1'b0;
   endtask : wr
   task automatic rd(logic [4:0] a);
      @(posedge clk) begin regRd <= 1'b1; regAddr <= a; end
      @(posedge clk) regRd <= 1'b0;
      #1 v = regRdata;
   endtask : rd
   task automatic pulse(int i);
      @(posedge clk) ev[i] <= 1'b1;
      @(posedge clk) ev[i] <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : pulse
   task automatic t_events();
      for (int i = 0; i < 13; i++) begin
         @(posedge clk) anEnable <= (i != 12);
         pulse(i); chk("irq", 16'(!MASK_RESET[bitOf[i]]), 16'(irqN));
         rd(5'h11); chk("status", 16'h0001 << bitOf[i], v);
         chk("irq off", 16'h0001, 16'(irqN));
         rd(5'h11); chk("cleared", 16'h0000, v);
      end
   endtask : t_events
   task automatic t_mask();
      wr(5'h1E, 16'h0008); n = irqCount;
      pulse(9); chk("irq", 16'h0000, 16'(irqN));
      rd(5'h11); wr(5'h1C, 16'h0001); wr(5'h1E, 16'h0000);
      pulse(9); chk("irq compat", 16'h0001, 16'(irqN));
      rd(5'h1E); chk("mask", 16'h0008, v);
      chk("host", 16'h0001, 16'(irqCount - n));
      wr(5'h1C, 16'h0000); rd(5'h11); rd(5'h03); chk("unmapped", 16'h0000, v);
   endtask : t_mask
   task automatic t_setwins();
      @(posedge clk) begin regRd <= 1'b1; regAddr <= 5'h11; ev[9] <= 1'b1; end
      @(posedge clk) begin regRd <= 1'b0; ev[9] <= 1'b0; end
      #1 chk("old", 16'h0000, regRdata);
      rd(5'h11); chk("kept", 16'h0008, v);
   endtask : t_setwins
   task automatic t_jabber();
      for (int k = 0; k < 3; k++) begin
         @(posedge clk) begin speed100 <= (k == 2); txActive <= 1'b1; end
         repeat (JL + 5) @(posedge clk);
         #1 chk("cutoff", 16'(k != 2), 16'(txJabberCutoff));
         if (k == 1) begin rd(5'h01); chk("basic", 16'h0002, v & 16'h0002); end
         rd(5'h11); chk("jabber", (k == 0) ? 16'h0040 : 16'h0000, v);
         @(posedge clk) txActive <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : t_jabber
   task automatic t_elastic();
      for (int d = 0; d < 2; d++) begin
         @(posedge clk) begin ebPush <= (d == 0); ebPop <= (d == 1); end
         repeat (6) @(posedge clk);
         ebPush <= 1'b0; ebPop <= 1'b0; n = 0;
         repeat (3) begin #1 n += (frameAbort === 1'b1); @(posedge clk); end
         chk("abort", 16'h0001, 16'(n));
         rd(5'h11); chk("elastic", 16'h0100, v);
      end
   endtask : t_elastic
   task automatic finish_test();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : finish_test
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rd(5'h11); chk("reset", STATUS_RESET, v);
      t_events(); t_mask(); t_setwins(); t_jabber(); t_elastic();
      // idles that come with the delimiter are no premature end
      @(posedge clk) begin rxInFrame <= 1'b1; rxCodeStb <= 1'b1; rxCodeIdle <= 1'b1; end
      @(posedge clk) rxEsdSeen <= 1'b1;
      repeat (2) @(posedge clk);
      rxCodeStb <= 1'b0; rxInFrame <= 1'b0; rxEsdSeen <= 1'b0;
      rd(5'h11); chk("esd ends", 16'h0000, v);
      @(posedge clk) begin rxInFrame <= 1'b1; rxCodeStb <= 1'b1; rxCodeIdle <= 1'b1; end
      repeat (2) @(posedge clk);
      rxCodeStb <= 1'b0; rxInFrame <= 1'b0;
      rd(5'h11); chk("premature", 16'h1000, v);
      finish_test();
   end
endmodule : tb
